// *** digital_pattern_io_tb.sv ***
/*
 * Testbench of the pattern I/O block: register tasks, handshake
 * replay and capture, internal pacing, and the pattern FIFO.
 * Assumes dpio_pkg, dpio_top and dpio_uut_model are compiled first.
 */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module digital_pattern_io_tb;
	localparam logic [31:0] PAT = 32'ha5c30f96; // Replay pattern
	localparam logic [31:0] CAP = 32'h5a3ce187; // Captured words
	logic        aclk = 0, aresetn = 0, pol = 0, go = 0;
	logic [7:0]  awaddr = 0, araddr = 0;
	logic [3:0]  wstrb = 4'hf;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, hs_req, hs_ack, hs_stb;
	logic [1:0]  bresp, rresp, r;
	logic [31:0] wdata = 0, rdata, pin_o, pin_oe_n, uut_pins, pin_w, word = 0;
	logic [31:0] d, t, idx;
	int          fail_count = 0, n_tests = 0, cyc = 0, lat, wid, n, i;

	always #20 aclk = ~aclk; // 25 MHz
	always @(posedge aclk) cyc <= cyc + 1;
	// Wire level: an undriven pin shows the partner's value
	assign pin_w = (pin_oe_n & uut_pins) | (~pin_oe_n & pin_o);

	dpio_top #(.DIV_MAX(1000), .PER_MAX(2000)) u_dpio_top (.aclk, .aresetn, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .pin_i(pin_w), .pin_o, .pin_oe_n, .hs_req,
		.hs_ack, .hs_stb);
	dpio_uut_model u_dpio_uut_model (.aclk, .aresetn, .pol, .go, .word, .hs_req, .pins(uut_pins));

	////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// One comparison
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// A wait ran out
	task automatic tmo();
		fail_count++;
		$display("CHECK FAILED wait expected answer seen timeout");
		conclude();
	endtask
	task automatic tend(input string s);
		$display("test %s finished", s);
	endtask
	// Register write; response code lands in r
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int k;
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1;
		wvalid  <= 1;
		bready  <= 1;
		for (k = 0; k < 3000; k++) begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 0;
		if (k == 3000) tmo();
		@(posedge aclk);
	endtask
	// Register read into d and r
	task automatic rd(input logic [7:0] a);
		int k;
		araddr  <= a;
		arvalid <= 1;
		rready  <= 1;
		for (k = 0; k < 3000; k++) begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 0;
		if (k == 3000) tmo();
		@(posedge aclk);
	endtask
	// One request; times strobe or ack from the sampling edge, at negedges
	task automatic hs_time(input logic [31:0] w, input bit stb);
		int k;
		word <= w;
		go   <= 1;
		@(posedge aclk);
		go <= 0;
		for (k = 0; k < 20 && hs_req !== pol; k++) @(negedge aclk);
		lat = 0;
		for (k = 0; k < 300; k++) begin
			@(negedge aclk);
			if ((stb ? hs_stb : hs_ack) === pol) break;
			lat++;
		end
		if (k == 300) tmo();
		for (wid = 0; wid < 300 && (stb ? hs_stb : hs_ack) === pol; wid++) @(negedge aclk);
		@(posedge aclk);
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		// Idle levels, unmapped place, depth limits
		chk("oe_n", pin_oe_n, 32'hffffffff);
		chk("ack idle", hs_ack, 1);
		chk("stb idle", hs_stb, 1);
		rd(dpio_pkg::A_CTRL);
		chk("ctrl", d, 0);
		rd(8'h48);
		chk("rresp", r, dpio_pkg::R_SLVERR);
		wr(8'h48, 0);
		chk("bresp", r, dpio_pkg::R_SLVERR);
		wr(dpio_pkg::A_PRE, 4095);
		rd(dpio_pkg::A_PRE);
		chk("pre", d, 4095);
		wr(dpio_pkg::A_POST, 4096);
		rd(dpio_pkg::A_POST);
		chk("post", d, 4096);
		tend("reset");
		// Both polarities: handshake replay, then handshake capture
		for (i = 0; i < 2; i++) begin
			t = i ? 32'h38 : 32'h0;
			// Stop whatever ran before, so the pattern load can drain
			wr(dpio_pkg::A_CTRL, 32'h80);
			wr(dpio_pkg::A_DIR, 32'h0000ffff);
			wr(dpio_pkg::A_OC, 32'h00ff0000);
			for (n = 0; n < 2; n++) begin
				wr(dpio_pkg::A_PADR, n);
				wr(dpio_pkg::A_PDAT, PAT ^ {32{n[0]}});
			end
			wr(dpio_pkg::A_PLEN, 2);
			wr(dpio_pkg::A_RCNT, 1);
			wr(dpio_pkg::A_CTRL, t);
			pol <= i[0];
			wr(dpio_pkg::A_CTRL, t | 32'h6);
			for (n = 0; n < 2; n++) begin
				hs_time(0, 1);
				chk("stb lat", lat, 0);
				chk("stb wid", wid, dpio_pkg::ACK_CYC);
				d = PAT ^ {32{n[0]}};
				chk("pin_o", pin_o & 32'h00ffffff, d & 32'h0000ffff);
				chk("oe_n", pin_oe_n, 32'hff000000 | (d & 32'h00ff0000));
				repeat (dpio_pkg::DIV_MIN) @(posedge aclk);
			end
			wr(dpio_pkg::A_DIR, 0);
			wr(dpio_pkg::A_OC, 0);
			wr(dpio_pkg::A_PRE, 0);
			wr(dpio_pkg::A_POST, 2);
			wr(dpio_pkg::A_MMSK, 0);
			wr(dpio_pkg::A_CTRL, t | 32'h5);
			for (n = 0; n < 2; n++) begin
				hs_time(CAP + n, 0);
				chk("ack lat", lat, dpio_pkg::HOLD_CYC);
				chk("ack wid", wid, dpio_pkg::ACK_CYC);
				repeat (dpio_pkg::DIV_MIN) @(posedge aclk);
			end
			rd(dpio_pkg::A_STAT);
			chk("cap done", d & 32'hf, 32'h8);
			rd(dpio_pkg::A_TRIG);
			idx = d;
			for (n = 0; n < 2; n++) begin
				wr(dpio_pkg::A_CADR, (idx + n) & 32'h1fff);
				rd(dpio_pkg::A_CDAT);
				chk("sample", d, CAP + n);
			end
			tend("handshake");
		end
		// Internal pacing at the fastest rate, no link activity
		wr(dpio_pkg::A_CTRL, 0);
		pol <= 0;
		wr(dpio_pkg::A_RATE, dpio_pkg::DIV_MIN);
		wr(dpio_pkg::A_POST, 3);
		wr(dpio_pkg::A_PRE, 2);
		wr(dpio_pkg::A_CTRL, 1);
		n = cyc;
		for (i = 0; i < 2000; i++) begin
			rd(dpio_pkg::A_STAT);
			if (d[3:0] === 4'h8) break;
		end
		if (i == 2000) tmo();
		n = cyc - n;
		chk("rate", n >= 2 * dpio_pkg::DIV_MIN && n <= 4 * dpio_pkg::DIV_MIN + 20, 1);
		chk("no ack", hs_ack, 1);
		tend("internal");
		// FIFO: a running replay holds the load back, so sixteen words fit and the next waits
		wr(dpio_pkg::A_PER, 600);
		wr(dpio_pkg::A_PADR, 0);
		wr(dpio_pkg::A_DIR, 32'hffffffff);
		wr(dpio_pkg::A_CTRL, 2);
		for (n = 0; n <= 16; n++) begin
			lat = cyc;
			wr(dpio_pkg::A_PDAT, PAT ^ n);
		end
		chk("fifo stall", cyc - lat > 100, 1);
		chk("fifo bresp", r, dpio_pkg::R_OKAY);
		repeat (20) @(posedge aclk);
		rd(dpio_pkg::A_PADR);
		chk("fifo drained", d, 17);
		// Continuous replay of the loaded words, in order, then stop
		wr(dpio_pkg::A_CTRL, 32'h42);
		for (n = 0; n < 2; n++) begin
			t = pin_o;
			for (i = 0; i < 2000 && pin_o === t; i++) @(posedge aclk);
			if (i == 2000) tmo();
			chk("fifo data", pin_o, PAT ^ n);
		end
		wr(dpio_pkg::A_CTRL, 32'h80);
		rd(dpio_pkg::A_STAT);
		chk("stopped", d[6:4], 1);
		tend("fifo");
		conclude();
	end
endmodule

// *** dpio_pkg.sv ***
/*
 * Shared constants of the digital pattern I/O block: register byte
 * offsets, control bit positions, reset values and timing figures.
 * Assumes a 25 MHz system clock.
 */
package dpio_pkg;
	// Clock
	localparam int unsigned CLK_HZ      = 25_000_000;
	localparam int unsigned CLK_NS      = 40;
	// Printed times and rates
	localparam int unsigned ACK_W_NS    = 1040;   // Ack/strobe width
	localparam int unsigned HOLD_NS     = 5300;   // Input hold after request
	localparam int unsigned UPD_NS      = 5210;   // Output update limit
	localparam int unsigned REQ_MIN_NS  = 50;     // Request pulse width
	localparam int unsigned RATE_HI_HZ  = 48_000;
	localparam int unsigned PER_MIN_NS  = 20_830; // Shortest repeat period
	// Cycle counts derived from the times (least up, longest down)
	localparam int unsigned ACK_CYC     = ACK_W_NS / CLK_NS;
	localparam int unsigned HOLD_CYC    = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned UPD_CYC     = UPD_NS / CLK_NS;
	localparam int unsigned REQ_CYC     = (REQ_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned DIV_MIN     = (CLK_HZ + RATE_HI_HZ - 1) / RATE_HI_HZ;
	localparam int unsigned PER_MIN     = (PER_MIN_NS + CLK_NS - 1) / CLK_NS;
	// Long counts: defaults of top parameters (3.662 Hz, 16 s)
	localparam int unsigned DIV_MAX_DEF = 6_826_870;
	localparam int unsigned PER_MAX_DEF = 400_000_000;
	// Depths
	localparam int unsigned PRE_MAX     = 4095;
	localparam int unsigned POST_MAX    = 4096;
	localparam int unsigned PAT_MAX     = 4096;
	// Register byte offsets
	localparam logic [7:0] A_CTRL  = 8'h00, A_DIR   = 8'h04, A_OC    = 8'h08;
	localparam logic [7:0] A_RATE  = 8'h0c, A_PRE   = 8'h10, A_POST  = 8'h14;
	localparam logic [7:0] A_MVAL  = 8'h18, A_MMSK  = 8'h1c, A_PLEN  = 8'h20;
	localparam logic [7:0] A_RCNT  = 8'h24, A_PER   = 8'h28, A_PADR  = 8'h2c;
	localparam logic [7:0] A_PDAT  = 8'h30, A_STAT  = 8'h34, A_CADR  = 8'h38;
	localparam logic [7:0] A_CDAT  = 8'h3c, A_PIN   = 8'h40, A_TRIG  = 8'h44;
	// Control bits (bits 0, 1, 7 are self-clearing commands)
	localparam int unsigned CB_CAP = 0, CB_PLAY = 1, CB_EXT = 2, CB_REQP = 3;
	localparam int unsigned CB_ACKP = 4, CB_STBP = 5, CB_CONT = 6, CB_STOP = 7;
	localparam logic [7:0] CTRL_RST = 8'h00;
	// Responses
	localparam logic [1:0] R_OKAY = 2'h0, R_SLVERR = 2'h2;
endpackage

// *** dpio_top.sv ***
/*
 * Digital pattern I/O: 32 pins, capture with match trigger, pattern
 * replay, AXI4-Lite registers, and a 16-word FIFO in the pattern path.
 * Assumes pins and request arrive synchronous to aclk.
 */
// Overview of operation
// [RULE_01] 32 pins, each input, output or open-collector
// [RULE_02] Request polarity programmable, low default; 50 ns pulses
// [RULE_03] Request inactive before handshake source selected
// [RULE_04] Input data valid at request, held 5.3 us
// [RULE_05] Acknowledge 1.04 us after hold time, programmable polarity
// [RULE_06] Pacing by handshake or 3.662 Hz-48 kHz generator
// [RULE_07] Up to 4095 pre-match, 4096 post-match samples
// [RULE_08] Clock, depth, levels common to all pins
// [RULE_09] Replay segment, period 20.83 us-16 s, repeat count
// [RULE_10] Handshake output update within 5.21 us
// [RULE_11] Strobe 1.04 us after update, programmable polarity
// [RULE_12] Match keeps pre samples, records post, stops
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module dpio_fifo #(
	parameter int unsigned W = 32,
	parameter int unsigned D = 16
) (
	// System
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int unsigned AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;  // Storage
		logic [AW-1:0]       wp;   // Write index
		logic [AW-1:0]       rp;   // Read index
		logic [AW:0]         cnt;  // Fill level
	} dpio_fifo_s;
	dpio_fifo_s r, n;
	logic push, pop;

	// Full and empty straight from the fill level
	assign in_ready  = r.cnt != (AW+1)'(D);
	assign out_valid = r.cnt != '0;
	assign out_data  = r.mem[r.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Next state
	always_comb begin
		n = r;
		if (push) begin
			n.mem[r.wp] = in_data;
			n.wp        = r.wp + 1'b1;
		end
		if (pop)
			n.rp = r.rp + 1'b1;
		n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////
module dpio_top #(
	parameter int unsigned DIV_MAX = dpio_pkg::DIV_MAX_DEF, // Slowest rate
	parameter int unsigned PER_MAX = dpio_pkg::PER_MAX_DEF  // Longest period
) (
	// System
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Pins: oe_n low while driving
	input  wire logic [31:0] pin_i,
	output logic [31:0]      pin_o,
	output logic [31:0]      pin_oe_n,
	// Handshake with the unit under test
	input  wire logic        hs_req,
	output logic             hs_ack,
	output logic             hs_stb
);
	typedef enum logic [3:0] {C_IDLE = 4'h1, C_PRE = 4'h2, C_POST = 4'h4, C_DONE = 4'h8} dpio_cap_e;
	typedef enum logic [2:0] {P_IDLE = 3'h1, P_RUN = 3'h2, P_WAIT = 3'h4} dpio_ply_e;
	typedef struct packed {
		logic        aw_h, w_h, awrdy, wrdy, bv, arrdy, rv; // Bus handshake
		logic [7:0]  aw_a;      // Held write address
		logic [31:0] w_d;       // Held write data
		logic [3:0]  w_s;       // Held strobes
		logic [1:0]  br, rr;    // Responses
		logic [31:0] rd;        // Read data
		logic [7:0]  ctrl;      // Control
		logic [31:0] dir, oc;   // Per-pin mode
		logic [22:0] rate;      // Sample divider
		logic [11:0] pre;       // Pre-match depth
		logic [12:0] post;      // Post-match depth
		logic [31:0] mval, mmsk;// Match value and mask
		logic [12:0] plen, rcnt;// Segment length, repeats
		logic [28:0] per;       // Repeat period in cycles
		logic [11:0] padr;      // Pattern load index
		logic [12:0] cadr;      // Capture read index
		logic [22:0] div;       // Rate divider count
		logic        req_p;     // Last request level
		dpio_cap_e   cs;        // Capture state
		logic [12:0] wp, trig, post_l;
		logic [11:0] pre_n;     // Pre samples held
		logic [7:0]  ack_c;     // Hold plus pulse countdown
		dpio_ply_e   ps;        // Replay state
		logic [11:0] rp;        // Replay index
		logic [12:0] reps;      // Repeats left
		logic [28:0] per_c;     // Period count
		logic [31:0] od;        // Current output sample
		logic [7:0]  stb_c;     // Strobe countdown
		logic [31:0] po, poe_n; // Pin drivers
		logic        ack, stb;  // Handshake pins
	} dpio_st_s;
	dpio_st_s r, n;
	// Sample memories kept outside the struct; copying them every
	// evaluation would cost far more than it would tidy
	logic [31:0] cap_mem [8192];
	logic [31:0] pat_mem [4096];
	logic        req_a, tick, itick, fin_v, fin_r, fout_v, fout_r, wfire, cap_we;
	logic [31:0] fout_d, wm, rv_w, rv_r;
	logic [22:0] eff_rate;
	logic        ok_w, ok_r;

	////////////////////////////////////////////////////////////////////
	// Register read view, shared by read and byte-lane merge
	function automatic logic [32:0] rdmux(input dpio_st_s s, input logic [7:0] a, input logic [31:0] cd, input logic [31:0] pi);
		logic [32:0] v;
		v = {1'b1, 32'h0};
		unique case (a)
			dpio_pkg::A_CTRL: v[7:0]   = s.ctrl;
			dpio_pkg::A_DIR:  v[31:0]  = s.dir;
			dpio_pkg::A_OC:   v[31:0]  = s.oc;
			dpio_pkg::A_RATE: v[22:0]  = s.rate;
			dpio_pkg::A_PRE:  v[11:0]  = s.pre;
			dpio_pkg::A_POST: v[12:0]  = s.post;
			dpio_pkg::A_MVAL: v[31:0]  = s.mval;
			dpio_pkg::A_MMSK: v[31:0]  = s.mmsk;
			dpio_pkg::A_PLEN: v[12:0]  = s.plen;
			dpio_pkg::A_RCNT: v[12:0]  = s.rcnt;
			dpio_pkg::A_PER:  v[28:0]  = s.per;
			dpio_pkg::A_PADR: v[11:0]  = s.padr;
			dpio_pkg::A_PDAT: v[31:0]  = 32'h0;
			dpio_pkg::A_STAT: v[19:0]  = {s.pre_n, 1'b0, s.ps, s.cs};
			dpio_pkg::A_CADR: v[12:0]  = s.cadr;
			dpio_pkg::A_CDAT: v[31:0]  = cd;
			dpio_pkg::A_PIN:  v[31:0]  = pi;
			dpio_pkg::A_TRIG: v[12:0]  = s.trig;
			default:          v        = 33'h0;
		endcase
		return v;
	endfunction

	// Request level after polarity; low-active by default
	assign req_a    = r.ctrl[dpio_pkg::CB_REQP] ? hs_req : !hs_req; // RULE_02
	// Clamp the divider into the documented rate span
	assign eff_rate = (r.rate < 23'(dpio_pkg::DIV_MIN)) ? 23'(dpio_pkg::DIV_MIN) :
	                  (r.rate > 23'(DIV_MAX)) ? 23'(DIV_MAX) : r.rate; // RULE_06
	assign itick    = r.div == eff_rate - 23'h1;
	// One pacing source serves both directions
	assign tick     = r.ctrl[dpio_pkg::CB_EXT] ? (req_a && !r.req_p) : itick; // RULE_06
	assign cap_we   = tick && (r.cs == C_PRE || r.cs == C_POST);
	assign {ok_w, rv_w} = rdmux(r, r.aw_a, cap_mem[r.cadr], pin_i);
	assign {ok_r, rv_r} = rdmux(r, araddr, cap_mem[r.cadr], pin_i);
	// Pattern words wait in the FIFO; a full FIFO holds the response back
	assign fin_v    = r.aw_h && r.w_h && !r.bv && r.aw_a == dpio_pkg::A_PDAT;
	assign wfire    = r.aw_h && r.w_h && !r.bv && (r.aw_a != dpio_pkg::A_PDAT || fin_r);
	// Loading is paused while a segment plays, so the FIFO really fills
	assign fout_r   = r.ps == P_IDLE;
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wm[8*b +: 8] = r.w_s[b] ? r.w_d[8*b +: 8] : rv_w[8*b +: 8];
		end
	end

	dpio_fifo #(.W(32), .D(16)) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (fin_v),
		.in_ready  (fin_r),
		.in_data   (r.w_d),
		.out_valid (fout_v),
		.out_ready (fout_r),
		.out_data  (fout_d)
	);

	////////////////////////////////////////////////////////////////////
	// Next state of bus slave, capture and replay
	always_comb begin
		n = r;
		n.ctrl[dpio_pkg::CB_CAP]  = 1'b0;
		n.ctrl[dpio_pkg::CB_PLAY] = 1'b0;
		n.ctrl[dpio_pkg::CB_STOP] = 1'b0;
		// Write address and data, taken in either order
		if (awvalid && r.awrdy) begin
			n.aw_h = 1'b1;
			n.aw_a = awaddr;
		end
		if (wvalid && r.wrdy) begin
			n.w_h = 1'b1;
			n.w_d = wdata;
			n.w_s = wstrb;
		end
		if (r.bv && bready)
			n.bv = 1'b0;
		if (wfire) begin
			n.aw_h = 1'b0;
			n.w_h  = 1'b0;
			n.bv   = 1'b1;
			n.br   = ok_w ? dpio_pkg::R_OKAY : dpio_pkg::R_SLVERR;
			unique case (r.aw_a)
				dpio_pkg::A_CTRL: n.ctrl = wm[7:0];
				dpio_pkg::A_DIR:  n.dir  = wm;     // RULE_01
				dpio_pkg::A_OC:   n.oc   = wm;     // RULE_01
				dpio_pkg::A_RATE: n.rate = wm[22:0];
				dpio_pkg::A_PRE:  n.pre  = (wm[12:0] > 13'(dpio_pkg::PRE_MAX)) ? 12'(dpio_pkg::PRE_MAX) : wm[11:0];
				dpio_pkg::A_POST: n.post = (wm[13:0] > 14'(dpio_pkg::POST_MAX)) ? 13'(dpio_pkg::POST_MAX) : wm[12:0];
				dpio_pkg::A_MVAL: n.mval = wm;
				dpio_pkg::A_MMSK: n.mmsk = wm;
				dpio_pkg::A_PLEN: n.plen = wm[12:0];
				dpio_pkg::A_RCNT: n.rcnt = wm[12:0];
				dpio_pkg::A_PER:  n.per  = wm[28:0];
				dpio_pkg::A_PADR: n.padr = wm[11:0];
				dpio_pkg::A_CADR: n.cadr = wm[12:0];
				default:          n.br   = ok_w ? dpio_pkg::R_OKAY : dpio_pkg::R_SLVERR;
			endcase
		end
		// Read: answer one cycle after the address is taken
		if (r.rv && rready)
			n.rv = 1'b0;
		if (arvalid && r.arrdy) begin
			n.rv = 1'b1;
			n.rd = rv_r;
			n.rr = ok_r ? dpio_pkg::R_OKAY : dpio_pkg::R_SLVERR;
		end
		n.awrdy = !n.aw_h && !n.bv;
		n.wrdy  = !n.w_h && !n.bv;
		n.arrdy = !n.rv;
		// Pattern load drains the FIFO
		if (fout_v && fout_r)
			n.padr = n.padr + 12'h1;
		// Internal rate generator
		n.div   = (itick || r.div >= eff_rate) ? 23'h0 : r.div + 23'h1; // RULE_06
		// Edge detector relies on an idle request at source selection
		n.req_p = req_a; // RULE_03
		// Capture sequence
		unique case (r.cs)
			C_IDLE, C_DONE: begin
				if (r.ctrl[dpio_pkg::CB_CAP]) begin
					n.cs    = C_PRE;
					n.pre_n = 12'h0;
				end
			end
			C_PRE: begin
				if (tick) begin
					n.wp    = r.wp + 13'h1;
					n.pre_n = (r.pre_n < r.pre) ? r.pre_n + 12'h1 : r.pre; // RULE_07
					// Masked match; older pre samples stay in the ring
					if (((pin_i ^ r.mval) & r.mmsk) == 32'h0) begin // RULE_12
						n.trig   = r.wp;
						n.post_l = r.post - 13'h1;
						n.cs     = (r.post <= 13'h1) ? C_DONE : C_POST;
					end
				end
			end
			C_POST: begin
				if (tick) begin
					n.wp     = r.wp + 13'h1;
					n.post_l = r.post_l - 13'h1; // RULE_07
					if (r.post_l == 13'h1)
						n.cs = C_DONE; // RULE_12
				end
			end
		endcase
		// Input acknowledge: wait out the hold, then pulse
		if (cap_we && r.ctrl[dpio_pkg::CB_EXT])
			n.ack_c = 8'(dpio_pkg::HOLD_CYC + dpio_pkg::ACK_CYC); // RULE_04
		else if (r.ack_c != 8'h0)
			n.ack_c = r.ack_c - 8'h1;
		// Replay sequence
		n.per_c = (r.per_c < 29'(PER_MAX)) ? r.per_c + 29'h1 : r.per_c;
		unique case (r.ps)
			P_IDLE: begin
				if (r.ctrl[dpio_pkg::CB_PLAY]) begin
					n.ps    = P_RUN;
					n.rp    = 12'h0;
					n.reps  = r.rcnt;
					n.per_c = 29'h0;
				end
			end
			P_RUN: begin
				if (tick) begin
					n.od = pat_mem[r.rp]; // RULE_10
					n.rp = r.rp + 12'h1;
					if (r.ctrl[dpio_pkg::CB_EXT])
						n.stb_c = 8'(dpio_pkg::ACK_CYC); // RULE_11
					if ({1'b0, r.rp} >= r.plen - 13'h1)
						n.ps = P_WAIT;
				end
			end
			P_WAIT: begin
				// Next segment starts one period after the last began
				// A period of zero cannot wrap the compare; the saturated counter also ends the wait
				if ((r.per_c + 29'h1 >= r.per || r.per_c == 29'(PER_MAX)) &&
				    r.per_c >= 29'(dpio_pkg::PER_MIN - 1)) begin // RULE_09
					n.rp    = 12'h0;
					n.per_c = 29'h0;
					n.reps  = r.reps - 13'h1;
					n.ps    = (r.ctrl[dpio_pkg::CB_CONT] || r.reps > 13'h1) ? P_RUN : P_IDLE;
				end
			end
		endcase
		if (r.stb_c != 8'h0 && !(tick && r.ps == P_RUN && r.ctrl[dpio_pkg::CB_EXT]))
			n.stb_c = r.stb_c - 8'h1;
		if (r.ctrl[dpio_pkg::CB_STOP]) begin
			n.cs = C_IDLE;
			n.ps = P_IDLE;
		end
		// Pins: one sample word and one mode per pin, shared timing
		n.po    = n.dir & ~n.oc & n.od;                 // RULE_01 RULE_08
		n.poe_n = ~(n.dir | n.oc) | (n.oc & n.od);      // RULE_01
		n.ack   = ((n.ack_c != 8'h0) && (n.ack_c <= 8'(dpio_pkg::ACK_CYC))) ~^ n.ctrl[dpio_pkg::CB_ACKP]; // RULE_05
		n.stb   = (n.stb_c != 8'h0) ~^ n.ctrl[dpio_pkg::CB_STBP]; // RULE_11
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r       <= '0;
			r.cs    <= C_IDLE;
			r.ps    <= P_IDLE;
			r.ctrl  <= dpio_pkg::CTRL_RST;
			r.poe_n <= '1;
			r.ack   <= 1'b1;
			r.stb   <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// Sample memories
	always_ff @(posedge aclk) begin
		if (cap_we)
			cap_mem[r.wp] <= pin_i;
		if (fout_v && fout_r)
			pat_mem[r.padr] <= fout_d;
	end

	assign awready  = r.awrdy;
	assign wready   = r.wrdy;
	assign bvalid   = r.bv;
	assign bresp    = r.br;
	assign arready  = r.arrdy;
	assign rvalid   = r.rv;
	assign rdata    = r.rd;
	assign rresp    = r.rr;
	assign pin_o    = r.po;
	assign pin_oe_n = r.poe_n;
	assign hs_ack   = r.ack;
	assign hs_stb   = r.stb;

	////////////////////////////////////////////////////////////////////
	// Checks
	logic ack_on, stb_on, ext_cap, ext_out;
	assign ack_on  = r.ack == r.ctrl[dpio_pkg::CB_ACKP];
	assign stb_on  = r.stb == r.ctrl[dpio_pkg::CB_STBP];
	assign ext_cap = cap_we && r.ctrl[dpio_pkg::CB_EXT];
	assign ext_out = tick && r.ps == P_RUN && r.ctrl[dpio_pkg::CB_EXT];
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_ACK_HOLD: assert property (ext_cap |-> ##1 (!ack_on)[*8] ##125 !ack_on ##1 ack_on) // RULE_05
		else $error("acknowledge not at hold end");
	AST_ACK_WIDTH: assert property ($rose(ack_on) && !ext_cap |-> ##25 ack_on ##1 !ack_on) // RULE_05
		else $error("acknowledge width wrong");
	AST_STB_UPD: assert property (ext_out |=> stb_on && r.od == pat_mem[$past(r.rp)]) // RULE_10
		else $error("output not updated on request");
	AST_STB_WIDTH: assert property ($rose(stb_on) |-> stb_on[*8] ##18 stb_on ##1 !stb_on) // RULE_11
		else $error("strobe width wrong");
	AST_REQ_POL: assert property (r.ctrl[dpio_pkg::CB_EXT] && $past(r.ctrl[dpio_pkg::CB_EXT]) && r.ps == P_RUN &&
		hs_req == r.ctrl[dpio_pkg::CB_REQP] && $past(hs_req) != r.ctrl[dpio_pkg::CB_REQP] |=> stb_on) // RULE_02
		else $error("request polarity ignored");
	AST_RATE: assert property (itick && !r.ctrl[dpio_pkg::CB_EXT] |=> (!itick)[*8] ##1 (!itick)[*8]) // RULE_06
		else $error("internal rate too fast");
	AST_PRE: assert property (r.cs == C_PRE && tick && r.pre_n < r.pre |=> r.pre_n == $past(r.pre_n) + 12'h1) // RULE_07
		else $error("pre-match count not kept");
	AST_POST: assert property (r.cs == C_POST && tick && r.post_l == 13'h1 |=> r.cs == C_DONE ##1 r.wp == $past(r.wp)) // RULE_12
		else $error("capture did not stop");
	AST_PINS: assert property (((~(r.dir | r.oc)) & ~pin_oe_n) == 32'h0) // RULE_01
		else $error("input pin driven");
	AST_REPEAT: assert property (r.ps == P_WAIT && r.per_c + 29'h1 < r.per && r.per_c != 29'(PER_MAX) &&
		!r.ctrl[dpio_pkg::CB_STOP] |=> r.ps == P_WAIT) // RULE_09
		else $error("segment restarted early");
	COV_CAP: cover property (r.cs == C_POST ##1 r.cs == C_DONE);
	COV_HS: cover property (ext_cap ##[1:200] ack_on);
	COV_PLAY: cover property (r.ps == P_WAIT ##1 r.ps == P_RUN);
	COV_FULL: cover property (fin_v && !fin_r);
endmodule

// *** dpio_uut_model.sv ***
/*
 * Partner model: the unit under test on the request/acknowledge link.
 * Assumes go is a one-cycle pulse and that the bench spaces requests.
 */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
module dpio_uut_model (
	// System
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Bench control
	input  wire logic        pol,
	input  wire logic        go,
	input  wire logic [31:0] word,
	// Link side
	output logic             hs_req,
	output logic [31:0]      pins
);
	int cnt; // Cycles since the leading edge, 0 when idle

	// One request: edge with data, short pulse, data held, then spoiled
	always @(posedge aclk) begin
		if (!aresetn) begin
			hs_req <= ~pol;
			pins   <= 32'h0;
			cnt    <= 0;
		end else if (go) begin
			hs_req <= pol;
			pins   <= word;
			cnt    <= 1;
		end else if (cnt != 0) begin
			cnt <= cnt + 1;
			// Pulse kept just past the shortest legal width
			if (cnt == dpio_pkg::REQ_CYC + 1) hs_req <= ~pol;
			// Hold time over: the data no longer stays put
			if (cnt == dpio_pkg::HOLD_CYC + 1) begin
				pins <= ~pins;
				cnt  <= 0;
			end
		end else begin
			// Inactive level follows polarity, so selection is clean
			hs_req <= ~pol;
		end
	end
endmodule
